// ==== hdl/ssc_port.sv ====
// Purpose: APB-mapped serial shift/counter port with gated shift clock
// Assumes: mclk bus domain, lclk instruction-cycle link domain
// Notes:   Exchange crosses by toggle handshake with held data
//
// Notes on behaviour
// [R1] Shift clock depends only on sync, mode bit, carry and exchange.
// [R2] Exchange copies carry into gate latch; set latch passes sync pulses.
// [R3] Latch high in counter mode holds the shift clock high.
// [R4] Switching to shift mode with latch high starts pulses at once.
// [R5] Shift mode keeps shifting input, overwriting contents, even when halted.
// [R6] Exchange swaps serial register and accumulator.
// [R7] Counter decrements on input falls that stay low two instruction cycles.
// [R8] Serial register never freezes; no idle state stops it.
// [R9] Counter with steady input keeps its value, usable as storage.
// [R10] One exchange operation stores and retrieves together.
// [R11] While halted, state data leaves on the skip-status pin.
// [R12] Digit output register is write-only; reads return zero.
// [R13] Pulse source keeps each low pulse two instruction cycles or more; the bench also sends one half-cycle pulse, which must not count.
// [R14] Mode bit clear selects counter, set selects shift register.
// [R15] Shift mode moves one bit per instruction cycle, in low, out high.
`timescale 1ns/1ps
module ssc_port (
  // Bus clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  input  wire logic        lclk,
  input  wire logic        serialIn,
  output logic             shiftClk,
  output logic             serialOut,
  // Debug and digit outputs
  output logic             skipOut,
  output logic [3:0]       digitOut
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic        mode;
    logic        carry;
    logic        halt;
    logic [3:0]  acc;
    logic [3:0]  digit;
    logic        busy;
    logic        reqTgl;
    logic [3:0]  xAcc;
    logic        xCarry;
    logic        ackS1;
    logic        ackS2;
    logic        ackSeen;
    logic [7:0]  skipSh;
    logic [2:0]  skipCnt;
    logic [31:0] rdata;
  } ssc_core_st_t;

  ssc_core_st_t st_r;
  ssc_core_st_t st_nxt;
  logic         setupPh;
  logic         wrAcc;
  logic         rdAcc;

  ssc_xfer_if xif ();

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic addrMapped(input logic [7:0] a);
    return (a == ssc_pkg::ADDR_CTRL) || (a == ssc_pkg::ADDR_ACC)
        || (a == ssc_pkg::ADDR_EXCH) || (a == ssc_pkg::ADDR_DIGIT);
  endfunction

  assign setupPh = psel && !penable;
  assign wrAcc   = psel && penable && pwrite && addrMapped(paddr);
  assign rdAcc   = psel && penable && !pwrite;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Read data latched in setup, shown in access
    if (setupPh) begin
      case (paddr)
        ssc_pkg::ADDR_CTRL:  st_nxt.rdata = {29'h0, st_r.halt, st_r.carry, st_r.mode};
        ssc_pkg::ADDR_ACC:   st_nxt.rdata = {28'h0, st_r.acc};
        ssc_pkg::ADDR_EXCH:  st_nxt.rdata = {31'h0, st_r.busy};
        default:             st_nxt.rdata = 32'h0; // [R12]
      endcase
    end
    if (wrAcc) begin
      case (paddr)
        ssc_pkg::ADDR_CTRL: begin
          st_nxt.mode  = pwdata[ssc_pkg::CTRL_MODE_BIT];  // [R14]
          st_nxt.carry = pwdata[ssc_pkg::CTRL_CARRY_BIT];
          st_nxt.halt  = pwdata[ssc_pkg::CTRL_HALT_BIT];
        end
        ssc_pkg::ADDR_ACC: begin
          if (!st_r.busy) begin
            st_nxt.acc = pwdata[3:0];
          end
        end
        ssc_pkg::ADDR_EXCH: begin
          // One write both hands over the accumulator and fetches the register
          if (!st_r.busy) begin
            st_nxt.xAcc   = st_r.acc;     // [R10]
            st_nxt.xCarry = st_r.carry;   // [R2]
            st_nxt.reqTgl = ~st_r.reqTgl;
            st_nxt.busy   = 1'b1;
          end
        end
        default: begin
          st_nxt.digit = pwdata[3:0];     // [R12]
        end
      endcase
    end
    // Acknowledge from the link domain
    st_nxt.ackS1 = xif.ackTgl;
    st_nxt.ackS2 = st_r.ackS1;
    if (st_r.ackS2 != st_r.ackSeen) begin
      st_nxt.ackSeen = st_r.ackS2;
      st_nxt.acc     = xif.serialBack;    // [R6]
      st_nxt.busy    = 1'b0;
    end
    // State frame on the skip pin while halted
    if (!st_r.halt) begin
      st_nxt.skipSh  = 8'h00;
      st_nxt.skipCnt = 3'h0;
    end else if (st_r.skipCnt == 3'h0) begin
      st_nxt.skipSh  = {ssc_pkg::SKIP_MARK, st_r.mode, st_r.carry, st_r.busy, st_r.acc}; // [R11]
      st_nxt.skipCnt = ssc_pkg::SKIP_CNT_LAST;
    end else begin
      st_nxt.skipSh  = {st_r.skipSh[6:0], 1'b0};
      st_nxt.skipCnt = 3'(st_r.skipCnt - 1'b1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r       <= '0;
      st_r.acc   <= ssc_pkg::ACC_RST;
      st_r.digit <= ssc_pkg::DIGIT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata        = st_r.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !addrMapped(paddr);
  assign skipOut       = st_r.skipSh[7];
  assign digitOut      = st_r.digit;
  assign xif.reqTgl    = st_r.reqTgl;
  assign xif.xAcc      = st_r.xAcc;
  assign xif.xCarry    = st_r.xCarry;
  assign xif.modeShift = st_r.mode;

  // ----------------------------------------
  // Link side
  // ----------------------------------------
  ssc_link #(
    .SYNC_DIV (ssc_pkg::SYNC_DIV)
  ) u_link (
    .lclk  (lclk),
    .rst   (rst),
    .siPin (serialIn),
    .skPin (shiftClk),
    .soPin (serialOut),
    .xif   (xif.link)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_xchg_start;
    @(posedge mclk) disable iff (rst)
      wrAcc && paddr == ssc_pkg::ADDR_EXCH && !st_r.busy
      |=> st_r.busy && st_r.reqTgl != $past(st_r.reqTgl) && st_r.xAcc == $past(st_r.acc);
  endproperty
  a_xchg_start: assert property (p_xchg_start) else $error("exchange request not launched"); // [R10]

  property p_xchg_busy_hold;
    @(posedge mclk) disable iff (rst) st_r.busy && $stable(st_r.ackS2) && st_r.ackS2 == st_r.ackSeen
      |=> $stable(st_r.reqTgl) && $stable(st_r.xAcc) && $stable(st_r.xCarry);
  endproperty
  a_xchg_busy_hold: assert property (p_xchg_busy_hold) else $error("exchange data moved while busy"); // [R6]

  property p_xchg_done;
    @(posedge mclk) disable iff (rst) $fell(st_r.busy) |-> st_r.acc == $past(xif.serialBack);
  endproperty
  a_xchg_done: assert property (p_xchg_done) else $error("accumulator did not take register"); // [R6]

  property p_xchg_bounded;
    @(posedge mclk) disable iff (rst) $rose(st_r.busy) |-> ##[1:40] !st_r.busy;
  endproperty
  a_xchg_bounded: assert property (p_xchg_bounded) else $error("exchange never finished"); // [R10]

  property p_digit_wo;
    @(posedge mclk) disable iff (rst) rdAcc && paddr == ssc_pkg::ADDR_DIGIT |-> prdata == 32'h0;
  endproperty
  a_digit_wo: assert property (p_digit_wo) else $error("digit register readable"); // [R12]

  property p_skip_quiet;
    @(posedge mclk) disable iff (rst) !st_r.halt ##1 !st_r.halt |-> !skipOut;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("skip pin active outside halt"); // [R11]

  property p_skip_mark;
    @(posedge mclk) disable iff (rst) st_r.halt && st_r.skipCnt == 3'h0 |=> skipOut == ssc_pkg::SKIP_MARK;
  endproperty
  a_skip_mark: assert property (p_skip_mark) else $error("skip frame lacks marker"); // [R11]

  c_xchg:   cover property (@(posedge mclk) disable iff (rst) $fell(st_r.busy));
  c_halt:   cover property (@(posedge mclk) disable iff (rst) st_r.halt && skipOut);
  c_unmap:  cover property (@(posedge mclk) disable iff (rst) pslverr);
endmodule

// ==== include/ssc_pkg.sv ====
// Purpose: Shared constants of the serial shift/counter port
// Assumes: 32-bit APB data, 4-bit accumulator and serial register
// Notes:   Register offsets are byte addresses
package ssc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int         APB_AW     = 8;
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_ACC   = 8'h04;
  localparam logic [7:0] ADDR_EXCH  = 8'h08;
  localparam logic [7:0] ADDR_DIGIT = 8'h0c;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int         CTRL_MODE_BIT  = 0;
  localparam int         CTRL_CARRY_BIT = 1;
  localparam int         CTRL_HALT_BIT  = 2;
  localparam int         EXCH_BUSY_BIT  = 0;
  localparam int         NIB_W          = 4;
  localparam logic [3:0] ACC_RST        = 4'h0;
  localparam logic [3:0] SREG_RST       = 4'h0;
  localparam logic [3:0] DIGIT_RST      = 4'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         SYNC_DIV       = 4;
  localparam int         LOW_MIN_INSTR  = 2;
  localparam logic [1:0] LOW_MIN_CNT    = 2'(LOW_MIN_INSTR);
  localparam int         SKIP_FRAME_W   = 8;
  localparam logic [2:0] SKIP_CNT_LAST  = 3'(SKIP_FRAME_W - 1);
  localparam logic       SKIP_MARK      = 1'b1;

endpackage

// ==== include/ssc_xfer_if.sv ====
// Purpose: Exchange handshake between the bus side and the link side
// Assumes: Toggle request and toggle acknowledge, data held across
// Notes:   No clocking block; both ends synchronise the toggles they read, not the held data
`timescale 1ns/1ps
interface ssc_xfer_if;
  logic       reqTgl;
  logic [3:0] xAcc;
  logic       xCarry;
  logic       modeShift;
  logic       ackTgl;
  logic [3:0] serialBack;

  modport core (output reqTgl, output xAcc, output xCarry, output modeShift,
                input ackTgl, input serialBack);
  modport link (input reqTgl, input xAcc, input xCarry, input modeShift,
                output ackTgl, output serialBack);
endinterface

// ==== hdl/ssc_link.sv ====
// Purpose: Link-side serial register, pulse counter and shift clock gate
// Assumes: lclk is the instruction-cycle source, free running
// Notes:   One sync pulse every SYNC_DIV link clocks
`timescale 1ns/1ps
module ssc_link #(
  parameter int SYNC_DIV = ssc_pkg::SYNC_DIV
) (
  // Clock and reset
  input  wire logic lclk,
  input  wire logic rst,
  // Pins
  input  wire logic siPin,
  output logic      skPin,
  output logic      soPin,
  // Bus side
  ssc_xfer_if.link  xif
);

  localparam int DW = (SYNC_DIV > 1) ? $clog2(SYNC_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(SYNC_DIV - 1);

  typedef struct packed {
    logic          modeS1;
    logic          modeS2;
    logic          modeS3;
    logic          reqS1;
    logic          reqS2;
    logic          reqSeen;
    logic          siS1;
    logic          siS2;
    logic [DW-1:0] div;
    logic          sync;
    logic          sk;
    logic          latch;
    logic [3:0]    sreg;
    logic [3:0]    back;
    logic          ack;
    logic [1:0]    lowCnt;
  } ssc_link_st_t;

  ssc_link_st_t st_r;
  ssc_link_st_t st_nxt;
  logic         xchgEv;
  logic         decEv;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.modeS1 = xif.modeShift;
    st_nxt.modeS2 = st_r.modeS1;
    st_nxt.modeS3 = st_r.modeS2; // Pin logic reads this stage, never the first flop
    st_nxt.reqS1  = xif.reqTgl;
    st_nxt.reqS2  = st_r.reqS1;
    st_nxt.siS1   = siPin;
    st_nxt.siS2   = st_r.siS1;
    st_nxt.div    = (st_r.div == DIV_LAST) ? '0 : DW'(st_r.div + 1'b1);
    st_nxt.sync   = (st_nxt.div == '0);
    xchgEv        = (st_r.reqS2 != st_r.reqSeen);
    decEv         = 1'b0;
    // Low time measured in sync samples; a count needs two low samples
    if (st_r.sync) begin
      if (st_r.siS2) begin
        st_nxt.lowCnt = 2'h0;
      end else if (st_r.lowCnt < ssc_pkg::LOW_MIN_CNT) begin
        st_nxt.lowCnt = 2'(st_r.lowCnt + 1'b1);
        decEv = !st_r.modeS3 && (st_r.lowCnt == 2'(ssc_pkg::LOW_MIN_CNT - 1)); // [R7] [R13]
      end
    end
    // Exchange wins; a pulse landing on it is lost
    if (xchgEv) begin
      st_nxt.reqSeen = st_r.reqS2;
      st_nxt.back    = st_r.sreg;     // [R6]
      st_nxt.sreg    = xif.xAcc;      // [R6] [R10]
      st_nxt.latch   = xif.xCarry;    // [R2]
      st_nxt.ack     = ~st_r.ack;
    end else if (st_r.sync && st_r.modeS3) begin
      st_nxt.sreg = {st_r.sreg[2:0], st_r.siS2}; // [R5] [R8] [R15] [R14]
    end else if (decEv) begin
      st_nxt.sreg = 4'(st_r.sreg - 1'b1); // [R7] [R9]
    end
    st_nxt.sk = st_nxt.latch & (st_nxt.modeS3 ? st_nxt.sync : 1'b1); // [R1] [R2] [R3] [R4] [R14]
  end

  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      st_r        <= '0;
      st_r.sreg   <= ssc_pkg::SREG_RST;
      st_r.back   <= ssc_pkg::SREG_RST;
      st_r.lowCnt <= ssc_pkg::LOW_MIN_CNT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign skPin          = st_r.sk;
  assign soPin          = st_r.sreg[3];
  assign xif.ackTgl     = st_r.ack;
  assign xif.serialBack = st_r.back;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [3:0] shiftExp;
  logic [3:0] decExp;
  assign shiftExp = {st_r.sreg[2:0], st_r.siS2};
  assign decExp   = 4'(st_r.sreg - 1'b1);

  property p_sk_off;
    @(posedge lclk) disable iff (rst) !st_r.latch |-> !skPin;
  endproperty
  a_sk_off: assert property (p_sk_off) else $error("shift clock active with gate latch low"); // [R1]

  property p_sk_count_high;
    @(posedge lclk) disable iff (rst) st_r.latch && !st_r.modeS3 |-> skPin;
  endproperty
  a_sk_count_high: assert property (p_sk_count_high) else $error("shift clock not high in counter mode"); // [R3]

  property p_sk_pulse;
    @(posedge lclk) disable iff (rst)
      st_r.latch && st_r.modeS3 && !xchgEv |-> skPin == st_r.sync;
  endproperty
  a_sk_pulse: assert property (p_sk_pulse) else $error("shift clock does not follow sync"); // [R2] [R4]

  property p_xchg;
    @(posedge lclk) disable iff (rst)
      xchgEv |=> st_r.sreg == $past(xif.xAcc) && st_r.back == $past(st_r.sreg)
                 && st_r.latch == $past(xif.xCarry) && xif.ackTgl != $past(xif.ackTgl);
  endproperty
  a_xchg: assert property (p_xchg) else $error("exchange did not swap register"); // [R6]

  property p_shift;
    @(posedge lclk) disable iff (rst) st_r.sync && st_r.modeS3 && !xchgEv |=> st_r.sreg == $past(shiftExp);
  endproperty
  a_shift: assert property (p_shift) else $error("serial register did not shift"); // [R15]

  property p_count;
    @(posedge lclk) disable iff (rst) decEv && !xchgEv |=> st_r.sreg == $past(decExp);
  endproperty
  a_count: assert property (p_count) else $error("counter did not decrement"); // [R7]

  property p_count_hold;
    @(posedge lclk) disable iff (rst) !st_r.modeS3 && !xchgEv && !decEv |=> $stable(st_r.sreg);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter changed without pulse"); // [R9]

  c_count: cover property (@(posedge lclk) disable iff (rst) decEv);
  c_shift_sk: cover property (@(posedge lclk) disable iff (rst) st_r.modeS3 && skPin);
endmodule

// ==== dv/ssc_far_end.sv ====
// Purpose: Far-side serial peripheral and pulse source for the shift/counter port
// Assumes: Shift data changes only after the device has taken a bit
// Notes:   Behavioural; four link clocks make one instruction cycle
`timescale 1ns/1ps
module ssc_far_end (
  // Link pins
  input  wire logic lclk,
  input  wire logic shiftClk,
  input  wire logic serialOut,
  output logic      serialIn,
  // Bench control
  input  wire logic shiftData
);
  bit   pulsing = 1'b0;
  int   skCount = 0;
  logic outSeen = 1'b0;

  initial serialIn = 1'b1;

  // New bit only after a shift clock, so it is stable at the next one
  always @(posedge lclk) begin
    if (shiftClk) begin
      skCount <= skCount + 1;
      outSeen <= serialOut;
      if (!pulsing) begin
        serialIn <= shiftData;
      end
    end
  end

  // Low time given in link clocks
  task automatic send_pulses(input int n, input int lowLen);
    pulsing = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge lclk);
      serialIn <= 1'b0;
      repeat (lowLen) @(posedge lclk);
      serialIn <= 1'b1;
      repeat (16) @(posedge lclk);
    end
    pulsing = 1'b0;
  endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: Self-checking bench of the serial shift/counter port
// Assumes: Zero-wait APB slave, exchange completes within 40 polls
// Notes:   Link clock 15 ns, unrelated to the 50 ns bus clock
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module tb;
  logic        mclk = 1'b0;
  logic        lclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serialIn;
  logic        shiftClk;
  logic        serialOut;
  logic        skipOut;
  logic [3:0]  digitOut;
  logic        shiftData = 1'b1;
  int          error_cnt = 0;
  int          checks_done = 0;

  initial forever #25 mclk = ~mclk;
  initial begin
    #3.1;
    forever #7.5 lclk = ~lclk;
  end

  ssc_port ssc_port_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lclk(lclk),
    .serialIn(serialIn), .shiftClk(shiftClk), .serialOut(serialOut), .skipOut(skipOut), .digitOut(digitOut));
  ssc_far_end ssc_far_end_inst (.lclk(lclk), .shiftClk(shiftClk), .serialOut(serialOut),
    .serialIn(serialIn), .shiftData(shiftData));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, exp, r)
  endtask

  task automatic exchange();
    logic [31:0] r;
    logic        e;
    int          i;
    wr(ssc_pkg::ADDR_EXCH, 32'h0);
    for (i = 0; i < 40; i++) begin
      apb(1'b0, ssc_pkg::ADDR_EXCH, 32'h0, r, e);
      if (r[ssc_pkg::EXCH_BUSY_BIT] === 1'b0) break;
    end
    if (i == 40) begin
      error_cnt++;
      test_done();
    end
  endtask

  // Shift clocks counted by the far side over 40 link clocks
  task automatic sk_count(output int n);
    int s;
    @(posedge lclk);
    s = ssc_far_end_inst.skCount;
    repeat (40) @(posedge lclk);
    n = ssc_far_end_inst.skCount - s;
  endtask

  task automatic skip_seen(output logic s);
    s = 1'b0;
    repeat (16) begin
      @(posedge mclk);
      s = s | skipOut;
    end
  endtask

  task automatic t_reset_map();
    logic [31:0] r;
    logic        e;
    rd_chk("ctrl", ssc_pkg::ADDR_CTRL, 32'h0);
    rd_chk("acc", ssc_pkg::ADDR_ACC, 32'h0);
    wr(ssc_pkg::ADDR_DIGIT, 32'h5);
    @(posedge mclk);
    `CHK("digitOut", 4'h5, digitOut)
    rd_chk("digit", ssc_pkg::ADDR_DIGIT, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    `CHK("shiftClk idle", 1'b0, shiftClk)
    $display("test reset_map done");
  endtask

  task automatic t_counter();
    logic hi;
    wr(ssc_pkg::ADDR_ACC, 32'ha);
    wr(ssc_pkg::ADDR_CTRL, 32'h2);
    exchange();
    rd_chk("acc old reg", ssc_pkg::ADDR_ACC, 32'h0);
    hi = 1'b1;
    repeat (20) begin
      @(posedge lclk);
      hi = hi & shiftClk;
    end
    `CHK("shiftClk held", 1'b1, hi)
    exchange();
    rd_chk("acc stored", ssc_pkg::ADDR_ACC, 32'ha);
    exchange();
    ssc_far_end_inst.send_pulses(1, 2);
    ssc_far_end_inst.send_pulses(3, 8);
    exchange();
    rd_chk("acc counted", ssc_pkg::ADDR_ACC, 32'h7);
    $display("test counter done");
  endtask

  task automatic t_shift();
    int   n;
    logic s;
    wr(ssc_pkg::ADDR_CTRL, 32'h7);
    repeat (6) @(posedge lclk);
    sk_count(n);
    `CHK("shift clocks", 10, n)
    repeat (20) @(posedge lclk);
    `CHK("serial out ones", 1'b1, ssc_far_end_inst.outSeen)
    skip_seen(s);
    `CHK("skip active", 1'b1, s)
    exchange();
    rd_chk("acc shifted", ssc_pkg::ADDR_ACC, 32'hf);
    shiftData <= 1'b0;
    repeat (40) @(posedge lclk);
    `CHK("serial out zeros", 1'b0, ssc_far_end_inst.outSeen)
    exchange();
    rd_chk("acc overwritten", ssc_pkg::ADDR_ACC, 32'h0);
    wr(ssc_pkg::ADDR_CTRL, 32'h1);
    exchange();
    repeat (8) @(posedge lclk);
    sk_count(n);
    `CHK("gate closed", 0, n)
    skip_seen(s);
    `CHK("skip quiet", 1'b0, s)
    $display("test shift done");
  endtask

  initial begin
    #200000;
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset_map();
    t_counter();
    t_shift();
    test_done();
  end
endmodule
